/* hdl/adc_rate_mode_reference_config.sv */
// Added by the designer: the Avalon-MM register port.
`default_nettype none
module adc_rate_mode_reference_config
    import cfg_pkg::*;
#(
    parameter int clk_khz = nominal_clk_khz // master clock, for rate scaling
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,        // word address
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [1:0]  response,
    input  wire logic        conversion_done, // converter finished a conversion
    output var conv_cfg_s    cfg,             // settings of the running conversion
    output logic             converting
);
    // whole module state
    typedef struct packed {
        logic [7:0]  reg1;        // rate_mode_config
        logic [7:0]  reg2;        // reference_filter_current_config
        logic [31:0] rdata;
        logic        ack;         // one-cycle answer (waitrequest low)
        logic [1:0]  resp;
        logic        busy;
        logic        sw_closed;
        conv_cfg_s   live;        // latched at conversion start; low_side_switch_closed follows the switch every cycle
    } state_s;

    state_s st;
    state_s next_st;

    // decoded views of the stored registers
    logic [17:0] dec_rate;
    logic        dec_valid;
    logic [10:0] dec_excite;
    logic [17:0] scaled_rate;

    // rate decode per mode; the excitation decode is shared by both sources
    rate_decode u_rate (
        .rate_select (st.reg1[rate_select_lsb +: 3]),
        .op_mode     (st.reg1[op_mode_lsb +: 2]),
        .rate_csps   (dec_rate),
        .valid       (dec_valid)
    );

    excite_decode u_excite (
        .code     (st.reg2[excitation_lsb +: 3]),
        .level_ua (dec_excite)
    );

    // rates scale with the master clock
    // wide product so that a fast master clock cannot overflow the multiply; the result is cut to 18 bits and wraps above 262143
    always_comb begin
        scaled_rate = 18'((64'(dec_rate) * 64'(clk_khz)) / 64'(nominal_clk_khz));
    end

    logic sel_write; // accepted write this cycle
    logic sel_read;
    logic launch;    // start command
    logic sleep;     // sleep_entry_command
    logic mapped;

    // next-state logic: bus slave, command pulses, conversion latch
    always_comb begin
        next_st  = st;
        next_st.ack  = 1'b0;
        sel_write = write && !st.ack;
        sel_read  = read && !write && !st.ack;
        // known word addresses answer OKAY, holes answer a decode error
        mapped = (address == rate_mode_config_idx) ||
                 (address == reference_filter_current_config_idx) ||
                 (address == launch_control_idx) ||
                 (address == conversion_status_idx);
        // command pulses live only in the cycle in which the write is taken
        launch = 1'b0;
        sleep  = 1'b0;
        if (sel_write || sel_read) begin
            next_st.ack  = 1'b1;
            next_st.resp = mapped ? 2'h0 : 2'h3; // decode error for holes
            next_st.rdata = 32'h0;
        end
        if (sel_write && byteenable[0]) begin
            case (address)
                rate_mode_config_idx: begin
                    next_st.reg1 = writedata[7:0];
                end
                reference_filter_current_config_idx: begin
                    next_st.reg2 = writedata[7:0];
                end
                launch_control_idx: begin
                    launch = writedata[launch_start_pos];
                    sleep  = writedata[launch_sleep_pos];
                end
                default: begin
                end
            endcase
        end
        if (sel_read) begin
            case (address)
                rate_mode_config_idx:                next_st.rdata = {24'h0, st.reg1};
                reference_filter_current_config_idx: next_st.rdata = {24'h0, st.reg2};
                conversion_status_idx: next_st.rdata = {30'h0, st.sw_closed, st.busy};
                default:                             next_st.rdata = 32'h0;
            endcase
        end
        // low-side switch follows commands only when enabled
        if (!st.reg2[switch_mode_pos]) begin
            next_st.sw_closed = 1'b0;
        end else if (sleep) begin
            next_st.sw_closed = 1'b0;
        end else if (launch) begin
            next_st.sw_closed = 1'b1;
        end
        // conversion run: continuous restarts itself, single-shot stops
        if (sleep) begin
            next_st.busy = 1'b0;
        end else if (launch) begin
            next_st.busy = 1'b1;
        end else if (conversion_done && st.busy && !st.live.continuous) begin
            next_st.busy = 1'b0;
        end
        // settings are captured at each conversion start
        if (launch || (conversion_done && st.busy && st.live.continuous)) begin
            next_st.live.op_mode          = st.reg1[op_mode_lsb +: 2];
            next_st.live.sample_rate_csps = scaled_rate;
            next_st.live.rate_valid       = dec_valid;
            next_st.live.continuous       = st.reg1[conv_mode_pos];
            next_st.live.temp_sensor_enable = st.reg1[temp_sensor_pos];
            next_st.live.burnout_enable   = st.reg1[burnout_pos];
            next_st.live.ref_select       = st.reg1[temp_sensor_pos] ? ref_internal
                                            : st.reg2[ref_select_lsb +: 2];
            next_st.live.fir_select       = st.reg2[fir_select_lsb +: 2];
            next_st.live.excitation_current_level = dec_excite;
            next_st.live.bank_override    = st.reg1[temp_sensor_pos];
        end
        next_st.live.low_side_switch_closed = next_st.sw_closed;
    end

    // register the state
    always_ff @(posedge clk) begin
        // reset returns both registers to their reset values and stops the run
        if (rst) begin
            st      <= '0;
            st.reg1 <= rate_mode_config_reset;
            st.reg2 <= reference_filter_current_config_reset;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        readdata    = st.rdata;
        waitrequest = !st.ack;
        response    = st.resp;
        cfg         = st.live;
        converting  = st.busy;
    end

    // named steps that the checks below are built from
    // a request that the slave takes at this edge
    sequence s_taken;
        (read || write) && !st.ack;
    endsequence : s_taken
    // the answer: one cycle with waitrequest low, then high again
    sequence s_answer_once;
        !waitrequest ##1 waitrequest;
    endsequence : s_answer_once
    // a start command without a sleep in the same write
    sequence s_launch_only;
        launch && !sleep;
    endsequence : s_launch_only
    // a continuous run that finishes one conversion
    sequence s_restart;
        conversion_done && st.busy && st.live.continuous && !launch && !sleep;
    endsequence : s_restart

    // checks
    a_reg1_write: assert property (@(posedge clk) disable iff (rst)
        (write && !st.ack && byteenable[0] && address == rate_mode_config_idx)
        |=> st.reg1 == $past(writedata[7:0]))
        else $error("first register did not take write");
    a_reset_zero: assert property (@(posedge clk)
        rst |=> (st.reg1 == 8'h00 && st.reg2 == 8'h00))
        else $error("registers not cleared by reset");
    a_temp_ref: assert property (@(posedge clk) disable iff (rst)
        cfg.temp_sensor_enable |-> cfg.ref_select == ref_internal)
        else $error("temperature mode not on internal reference");
    a_switch_open: assert property (@(posedge clk) disable iff (rst)
        !st.reg2[switch_mode_pos] |=> !st.sw_closed)
        else $error("switch closed while mode bit clear");
    a_switch_close: assert property (@(posedge clk) disable iff (rst)
        (launch && !sleep && st.reg2[switch_mode_pos]) |=> st.sw_closed)
        else $error("switch did not close on launch");
    a_single_stop: assert property (@(posedge clk) disable iff (rst)
        (conversion_done && st.busy && !st.live.continuous && !launch && !sleep) |=> !st.busy)
        else $error("single shot did not stop");
    a_turbo_rate: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg1[7:3] == 5'h02 && clk_khz == nominal_clk_khz)
        |=> cfg.sample_rate_csps == 18'h00FA0)
        else $error("turbo code 0 not 40 SPS");
    a_duty_rate: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg1[7:3] == 5'h01 && clk_khz == nominal_clk_khz)
        |=> cfg.sample_rate_csps == 18'h001F4)
        else $error("duty code 0 not 5 SPS");
    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        s_taken |=> s_answer_once)
        else $error("bus answer not one cycle");
    a_excite_level: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg2[2:0] == 3'h7) |=> cfg.excitation_current_level == 11'h5DC)
        else $error("excitation code 7 not 1500 uA");

    // bus slave: accepted lanes, readback, decode, idle
    a_reg2_write: assert property (@(posedge clk) disable iff (rst)
        (write && !st.ack && byteenable[0] && address == reference_filter_current_config_idx)
        |=> st.reg2 == $past(writedata[7:0]))
        else $error("second register did not take write");
    a_lane_ignored: assert property (@(posedge clk) disable iff (rst)
        (write && !st.ack && !byteenable[0])
        |=> ($stable(st.reg1) && $stable(st.reg2)))
        else $error("write without low lane changed a register");
    a_read_back: assert property (@(posedge clk) disable iff (rst)
        (read && !write && !st.ack && address == rate_mode_config_idx)
        |=> readdata == {24'h00, $past(st.reg1)})
        else $error("first register readback wrong");
    a_status_read: assert property (@(posedge clk) disable iff (rst)
        (read && !write && !st.ack && address == conversion_status_idx)
        |=> readdata == {30'h0, $past(st.sw_closed), $past(st.busy)})
        else $error("status readback wrong");
    a_hole_decode: assert property (@(posedge clk) disable iff (rst)
        ((read || write) && !st.ack && !mapped)
        |=> response == 2'h3)
        else $error("unmapped access not a decode error");
    a_bus_idle: assert property (@(posedge clk) disable iff (rst)
        (!read && !write)
        |=> waitrequest)
        else $error("answer without a request");

    // run control: start, sleep, continuous restart
    a_launch_busy: assert property (@(posedge clk) disable iff (rst)
        s_launch_only
        |=> st.busy)
        else $error("start command did not begin a run");
    a_sleep_stop: assert property (@(posedge clk) disable iff (rst)
        sleep
        |=> (!st.busy && !st.sw_closed))
        else $error("sleep did not stop run and open switch");
    a_cont_restart: assert property (@(posedge clk) disable iff (rst)
        s_restart
        |=> st.busy)
        else $error("continuous run stopped");
    a_cont_relatch: assert property (@(posedge clk) disable iff (rst)
        s_restart
        |=> cfg.sample_rate_csps == $past(scaled_rate))
        else $error("continuous run did not take new rate");
    a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
        (!launch && !(conversion_done && st.busy && st.live.continuous))
        |=> $stable(cfg.sample_rate_csps))
        else $error("rate changed outside a conversion start");

    // fields captured at a conversion start
    a_mode_latch: assert property (@(posedge clk) disable iff (rst)
        s_launch_only
        |=> cfg.op_mode == $past(st.reg1[op_mode_lsb +: 2]))
        else $error("operating mode not captured");
    a_ref_latch: assert property (@(posedge clk) disable iff (rst)
        (launch && !st.reg1[temp_sensor_pos])
        |=> cfg.ref_select == $past(st.reg2[ref_select_lsb +: 2]))
        else $error("reference selection not captured");
    a_fir_latch: assert property (@(posedge clk) disable iff (rst)
        launch
        |=> cfg.fir_select == $past(st.reg2[fir_select_lsb +: 2]))
        else $error("filter selection not captured");
    a_burnout_latch: assert property (@(posedge clk) disable iff (rst)
        launch
        |=> cfg.burnout_enable == $past(st.reg1[burnout_pos]))
        else $error("burn-out setting not captured");
    a_temp_latch: assert property (@(posedge clk) disable iff (rst)
        launch
        |=> cfg.temp_sensor_enable == $past(st.reg1[temp_sensor_pos]))
        else $error("temperature mode not captured");
    a_bank_latch: assert property (@(posedge clk) disable iff (rst)
        launch
        |=> cfg.bank_override == $past(st.reg1[temp_sensor_pos]))
        else $error("bank override not set by temperature mode");
    a_conv_bit: assert property (@(posedge clk) disable iff (rst)
        launch
        |=> cfg.continuous == $past(st.reg1[conv_mode_pos]))
        else $error("conversion mode not captured");

    // decoded rates and currents
    a_rate_reserved: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg1[rate_select_lsb +: 3] == 3'h7)
        |=> !cfg.rate_valid)
        else $error("reserved rate code marked valid");
    a_normal_rate: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg1[7:3] == 5'h00 && clk_khz == nominal_clk_khz)
        |=> cfg.sample_rate_csps == 18'h007D0)
        else $error("normal code 0 not 20 SPS");
    a_duty_mid: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg1[7:3] == 5'h0D && clk_khz == nominal_clk_khz)
        |=> cfg.sample_rate_csps == 18'h01130)
        else $error("duty code 3 not 44 SPS");
    a_turbo_top: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg1[7:3] == 5'h1A && clk_khz == nominal_clk_khz)
        |=> cfg.sample_rate_csps == 18'h30D40)
        else $error("turbo code 6 not 2000 SPS");
    a_excite_reserved: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg2[2:0] == 3'h1)
        |=> cfg.excitation_current_level == 11'h000)
        else $error("reserved excitation code not off");
    a_excite_low: assert property (@(posedge clk) disable iff (rst)
        (launch && st.reg2[2:0] == 3'h2)
        |=> cfg.excitation_current_level == 11'h032)
        else $error("excitation code 2 not 50 uA");
endmodule : adc_rate_mode_reference_config
`default_nettype wire

/* hdl/cfg_pkg.sv */
`default_nettype none
package cfg_pkg;
    // register offsets (word index; byte address is four times this)
    localparam logic [7:0] rate_mode_config_idx                = 8'h01;
    localparam logic [7:0] reference_filter_current_config_idx = 8'h02;
    localparam logic [7:0] launch_control_idx                  = 8'h04;
    localparam logic [7:0] conversion_status_idx               = 8'h05;
    localparam logic [7:0] rate_mode_config_reset              = 8'h00;
    localparam logic [7:0] reference_filter_current_config_reset = 8'h00;
    // field positions
    localparam int rate_select_lsb   = 5;
    localparam int op_mode_lsb       = 3;
    localparam int conv_mode_pos     = 2;
    localparam int temp_sensor_pos   = 1;
    localparam int burnout_pos       = 0;
    localparam int ref_select_lsb    = 6;
    localparam int fir_select_lsb    = 4;
    localparam int switch_mode_pos   = 3;
    localparam int excitation_lsb    = 0;
    // launch control bits (write-one pulses)
    localparam int launch_start_pos  = 0;
    localparam int launch_sleep_pos  = 1;
    // operating modes
    localparam logic [1:0] mode_normal = 2'h0;
    localparam logic [1:0] mode_duty   = 2'h1;
    localparam logic [1:0] mode_turbo  = 2'h2;
    // reference selections
    localparam logic [1:0] ref_internal  = 2'h0;
    // modulator clock rates in kHz and the nominal master clock
    localparam int mod_clk_normal_khz = 256;
    localparam int mod_clk_turbo_khz  = 512;
    localparam int duty_ratio         = 4;
    localparam int nominal_clk_khz    = 4096;
    // rate table in centi-samples per second, normal mode, codes 0..6
    localparam logic [17:0] rate_normal_csps [7] = '{
        18'h007D0, 18'h01194, 18'h02328, 18'h0445C, 18'h080E8, 18'h0EA60, 18'h186A0};
    // rate table in centi-samples per second, duty-cycle mode, codes 0..6
    localparam logic [17:0] rate_duty_csps [7] = '{
        18'h001F4, 18'h00465, 18'h008CA, 18'h01130, 18'h0203A, 18'h03A98, 18'h061A8};
    // excitation current in uA, codes 0..7 (code 1 reserved, reads as off)
    localparam logic [10:0] excitation_ua [8] = '{
        11'h000, 11'h000, 11'h032, 11'h064, 11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC};
    // decoded configuration that leaves the block
    typedef struct packed {
        logic [1:0]  op_mode;           // effective operating mode
        logic [17:0] sample_rate_csps;  // rate scaled to the master clock, centi-samples/s
        logic        rate_valid;        // low for reserved rate or mode code
        logic        continuous;        // back-to-back conversions
        logic        temp_sensor_enable;
        logic        burnout_enable;
        logic [1:0]  ref_select;        // effective reference
        logic [1:0]  fir_select;
        logic        low_side_switch_closed;
        logic [10:0] excitation_current_level; // uA for both sources
        logic        bank_override;     // input_select/gain settings ignored
    } conv_cfg_s;
endpackage : cfg_pkg
`default_nettype wire

/* hdl/rate_decode.sv */
`default_nettype none
module rate_decode
    import cfg_pkg::*;
(
    input  wire logic [2:0]  rate_select,
    input  wire logic [1:0]  op_mode,
    output logic      [17:0] rate_csps,
    output logic             valid
);
    logic [17:0] base;      // normal-mode rate
    logic [17:0] base_duty; // duty-cycle rate
    // one code means a different rate per mode; turbo doubles normal, while duty
    // keeps a table of its own because not every code is a quarter of normal
    always_comb begin
        base      = (rate_select == 3'h7) ? 18'h00000 : rate_normal_csps[rate_select];
        base_duty = (rate_select == 3'h7) ? 18'h00000 : rate_duty_csps[rate_select];
        valid = (rate_select != 3'h7) && (op_mode != 2'h3);
        case (op_mode)
            mode_duty:  rate_csps = base_duty;
            mode_turbo: rate_csps = {base[16:0], 1'b0};
            default:    rate_csps = base;
        endcase
    end
endmodule : rate_decode
`default_nettype wire

/* hdl/excite_decode.sv */
`default_nettype none
module excite_decode
    import cfg_pkg::*;
(
    input  wire logic [2:0]  code,
    output logic      [10:0] level_ua
);
    // magnitude shared by both excitation sources
    always_comb begin
        level_ua = excitation_ua[code];
    end
endmodule : excite_decode
`default_nettype wire

/* tb/test_adc_rate_mode_reference_config.sv */
`default_nettype none
module test_adc_rate_mode_reference_config
    import cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;        // 100 MHz system clock
    logic        rst = 1'b1;        // synchronous reset
    logic [7:0]  address = 8'h00;   // word index
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
    logic        conversion_done = 1'b0; // pulse from the converter
    conv_cfg_s   cfg;
    logic        converting;
    int          err_count = 0;
    int          n_compared = 0;
    logic [31:0] rd;                // last read data
    logic [1:0]  rs;                // last read response
    int          m, c, k;
    logic [7:0]  r1, r2;            // shadow of the two registers
    adc_rate_mode_reference_config dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .conversion_done(conversion_done),
        .cfg(cfg), .converting(converting));
    // free-running clock
    always #5 clk = ~clk;
    // print counts and the verdict, then stop
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            err_count++;
            finish_test();
        end
        rd = readdata;
        rs = response;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    // start or sleep command, then let the latched settings settle
    task automatic cmd(input logic [31:0] d);
        bus(1'b1, 8'h04, d, 4'hF);
        repeat (2) @(posedge clk);
    endtask : cmd
    // one-cycle conversion finished pulse
    task automatic done_pulse();
        @(posedge clk) conversion_done <= 1'b1;
        @(posedge clk) conversion_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : done_pulse
    // expected rate in centi-samples per second for mode and code
    function automatic logic [31:0] exp_rate(input int md, input int cd);
        int nrm[7] = '{2000, 4500, 9000, 17500, 33000, 60000, 100000};
        int dty[7] = '{500, 1125, 2250, 4400, 8250, 15000, 25000};
        if (md == 1) return dty[cd];
        return (md == 2) ? 2 * nrm[cd] : nrm[cd];
    endfunction : exp_rate
    // main sequence
    initial begin
        int ua[8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};
        void'($urandom(81));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk({23'h0, cfg[40:32]}, 32'h0);
        chk(cfg[31:0], 32'h0);
        chk(converting, 0);
        bus(1'b0, 8'h01, 0, 4'hF); chk(rd, 32'h0);
        bus(1'b0, 8'h02, 0, 4'hF); chk(rd, 32'h0);
        // random writes and readback, mode kept legal
        for (k = 0; k < 8; k++) begin
            r1 = 8'($urandom) & 8'hEF;
            r2 = 8'($urandom) & 8'hCF;
            bus(1'b1, 8'h01, {24'h0, r1}, 4'hF);
            bus(1'b1, 8'h02, {24'h0, r2}, 4'hF);
            bus(1'b0, 8'h01, 0, 4'hF); chk(rd, {24'h0, r1});
            bus(1'b0, 8'h02, 0, 4'hF); chk(rd, {24'h0, r2});
        end
        // write without the low byte lane is ignored
        bus(1'b1, 8'h01, 32'hFF, 4'hE);
        bus(1'b0, 8'h01, 0, 4'hF); chk(rd, {24'h0, r1});
        // unmapped place and write-only command word
        bus(1'b1, 8'h07, 32'h5A, 4'hF);
        bus(1'b0, 8'h07, 0, 4'hF); chk(rs, 2'h3); chk(rd, 0);
        bus(1'b0, 8'h04, 0, 4'hF); chk(rd, 0);
        // every legal mode and every rate code, the reserved rate included
        for (m = 0; m < 3; m++) begin
            for (c = 0; c < 8; c++) begin
                bus(1'b1, 8'h01, {24'h0, c[2:0], m[1:0], 3'b000}, 4'hF);
                cmd(32'h1);
                chk(cfg.rate_valid, m != 3 && c != 7);
                if (m != 3) chk(cfg.op_mode, m);
                if (m != 3 && c != 7) chk(cfg.sample_rate_csps, exp_rate(m, c));
                cmd(32'h2);
            end
        end
        // reference, filter, excitation and burn-out fields
        for (c = 0; c < 8; c++) begin
            bus(1'b1, 8'h01, 32'h01, 4'hF);
            bus(1'b1, 8'h02, {24'h0, 5'b01100 | 5'(c >> 3), c[2:0]}, 4'hF);
            cmd(32'h1);
            chk(cfg.excitation_current_level, ua[c]);
            chk(cfg.ref_select, 2'h1);
            chk(cfg.fir_select, 2'h2);
            chk(cfg.burnout_enable, 1'b1);
            chk(cfg.low_side_switch_closed, 1'b0);
            cmd(32'h2);
        end
        // temperature mode forces the internal reference
        bus(1'b1, 8'h02, 32'hC0, 4'hF);
        bus(1'b1, 8'h01, 32'h02, 4'hF);
        cmd(32'h1);
        chk(cfg.ref_select, 2'h0);
        chk(cfg.bank_override, 1'b1);
        chk(cfg.temp_sensor_enable, 1'b1);
        cmd(32'h2);
        // low-side switch closes on start, opens on sleep
        bus(1'b1, 8'h02, 32'h08, 4'hF);
        cmd(32'h1);
        chk(cfg.low_side_switch_closed, 1'b1);
        bus(1'b0, 8'h05, 0, 4'hF); chk(rd, 32'h3);
        cmd(32'h2);
        chk(cfg.low_side_switch_closed, 1'b0);
        bus(1'b0, 8'h05, 0, 4'hF); chk(rd, 32'h0);
        // continuous run picks up new settings only at the next conversion
        bus(1'b1, 8'h01, 32'h44, 4'hF);
        cmd(32'h1);
        chk(converting, 1'b1);
        chk(cfg.continuous, 1'b1);
        bus(1'b1, 8'h01, 32'hA4, 4'hF);
        chk(cfg.sample_rate_csps, 9000);
        done_pulse();
        chk(converting, 1'b1);
        chk(cfg.sample_rate_csps, 60000);
        cmd(32'h2);
        chk(converting, 1'b0);
        // single shot stops after one conversion
        bus(1'b1, 8'h01, 32'h00, 4'hF);
        cmd(32'h1);
        chk(cfg.continuous, 1'b0);
        done_pulse();
        chk(converting, 1'b0);
        finish_test();
    end
endmodule : test_adc_rate_mode_reference_config
`default_nettype wire
